// ==== wct_regs.sv ====
// Threshold register bank with channel 4 window comparator
`timescale 1ns/10ps
`include "wct_params.svh"
module wct_regs #(
	parameter int DW = 12
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic sample_valid,
	input wire logic [2:0] sample_chan,
	input wire logic [DW-1:0] sample_data,
	output logic ch4_alert
);
	wct_pkg::wct_regs_s cur_reg;
	wct_pkg::wct_regs_s cur_next;
	logic [7:0] status_byte;

	wct_cfg_if #(.DW(DW)) cfg ();

	// Limits assembled from upper byte and upper nibble of the margin or count byte
	function automatic logic [DW-1:0] join_lim(input logic [7:0] ub,
		input logic [7:0] nib_reg);
		join_lim = DW'({ub, nib_reg[`WCT_NIB_UP]});
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a >= `WCT_OFS_CH3_LOW_EVT
			&& a <= `WCT_OFS_CH5_HIGH_MARG) || a == `WCT_OFS_STATUS;
	endfunction

	function automatic logic [7:0] read_byte(input wct_pkg::wct_regs_s s,
		input logic [7:0] a, input logic [7:0] st);
		if (a == `WCT_OFS_CH3_LOW_EVT)
			read_byte = s.ch3_low_evt;
		else if (a == `WCT_OFS_CH3_LOW_UB)
			read_byte = s.ch3_low_ub;
		else if (a == `WCT_OFS_CH4_HIGH_MARG)
			read_byte = s.ch4_high_marg;
		else if (a == `WCT_OFS_CH4_HIGH_UB)
			read_byte = s.ch4_high_ub;
		else if (a == `WCT_OFS_CH4_LOW_EVT)
			read_byte = s.ch4_low_evt;
		else if (a == `WCT_OFS_CH4_LOW_UB)
			read_byte = s.ch4_low_ub;
		else if (a == `WCT_OFS_CH5_HIGH_MARG)
			read_byte = s.ch5_high_marg;
		else if (a == `WCT_OFS_STATUS)
			read_byte = st;
		else
			read_byte = `WCT_RD_IDLE;
	endfunction

	// Live comparator state for software: alert, last sample out, count
	always_comb
	begin
		status_byte = `WCT_RST_ZERO;
		status_byte[`WCT_ST_ALERT] = cfg.alert;
		status_byte[`WCT_ST_OUT] = cfg.out_now;
		status_byte[`WCT_ST_CNT] = cfg.cnt;
	end

	always_comb
	begin
		cur_next = cur_reg;
		cur_next.rdata = `WCT_RD_IDLE;
		if (reg_wr)
		begin
			if (reg_addr == `WCT_OFS_CH3_LOW_EVT)
				cur_next.ch3_low_evt = reg_wdata;
			else if (reg_addr == `WCT_OFS_CH3_LOW_UB)
				cur_next.ch3_low_ub = reg_wdata;
			else if (reg_addr == `WCT_OFS_CH4_HIGH_MARG)
				cur_next.ch4_high_marg = reg_wdata;
			else if (reg_addr == `WCT_OFS_CH4_HIGH_UB)
				cur_next.ch4_high_ub = reg_wdata;
			else if (reg_addr == `WCT_OFS_CH4_LOW_EVT)
				cur_next.ch4_low_evt = reg_wdata;
			else if (reg_addr == `WCT_OFS_CH4_LOW_UB)
				cur_next.ch4_low_ub = reg_wdata;
			else if (reg_addr == `WCT_OFS_CH5_HIGH_MARG)
				cur_next.ch5_high_marg = reg_wdata;
		end
		// Unmapped reads answer zero rather than stalling the host
		if (reg_rd)
			cur_next.rdata = read_byte(cur_reg, reg_addr, status_byte);
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cur_reg.ch3_low_evt <= `WCT_RST_ZERO;
			cur_reg.ch3_low_ub <= `WCT_RST_ZERO;
			cur_reg.ch4_high_marg <= `WCT_RST_HIGH_MARG;
			cur_reg.ch4_high_ub <= `WCT_RST_HIGH_UB;
			cur_reg.ch4_low_evt <= `WCT_RST_ZERO;
			cur_reg.ch4_low_ub <= `WCT_RST_ZERO;
			cur_reg.ch5_high_marg <= `WCT_RST_HIGH_MARG;
			cur_reg.rdata <= `WCT_RD_IDLE;
		end
		else
			cur_reg <= cur_next;
	end

	// Only channel 4 has all four bytes here; its neighbours' halves are
	// held for software reads only and feed no comparator or output
	assign cfg.high_lim = join_lim(cur_reg.ch4_high_ub,
		cur_reg.ch4_high_marg);
	assign cfg.low_lim = join_lim(cur_reg.ch4_low_ub,
		cur_reg.ch4_low_evt);
	assign cfg.margin = cur_reg.ch4_high_marg[`WCT_NIB_LO];
	assign cfg.count_n = cur_reg.ch4_low_evt[`WCT_NIB_LO];
	assign cfg.smp_valid = sample_valid && sample_chan == `WCT_CH4_ID;
	assign cfg.smp_data = sample_data;
	assign cfg.alert_clr = reg_wr && reg_addr == `WCT_OFS_STATUS
		&& reg_wdata[`WCT_ST_ALERT];

	wct_window #(.DW(DW)) u_win (
		.clk(clk),
		.srst(srst),
		.cfg(cfg.cmp)
	);

	assign reg_rdata = cur_reg.rdata;
	assign ch4_alert = cfg.alert;

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	reset_high_a: assert property (
		$past(srst) |-> cur_reg.ch4_high_marg == `WCT_RST_HIGH_MARG
		&& cur_reg.ch4_high_ub == `WCT_RST_HIGH_UB
		&& cur_reg.ch5_high_marg == `WCT_RST_HIGH_MARG
		&& cfg.high_lim == '1 && cfg.margin == '0)
		else $error("high limit reset value wrong");
	reset_low_a: assert property (
		$past(srst) |-> cur_reg.ch4_low_evt == `WCT_RST_ZERO
		&& cur_reg.ch4_low_ub == `WCT_RST_ZERO
		&& cur_reg.ch3_low_evt == `WCT_RST_ZERO
		&& cur_reg.ch3_low_ub == `WCT_RST_ZERO && cfg.low_lim == '0)
		else $error("low limit or count reset value wrong");
	high_ub_map_a: assert property (
		reg_wr && reg_addr == `WCT_OFS_CH4_HIGH_UB
		|=> cfg.high_lim[DW-1:4] == $past(reg_wdata))
		else $error("high upper byte not on top bits");
	high_nib_map_a: assert property (
		reg_wr && reg_addr == `WCT_OFS_CH4_HIGH_MARG
		|=> cfg.high_lim[3:0] == $past(reg_wdata[`WCT_NIB_UP])
		&& cfg.margin == $past(reg_wdata[`WCT_NIB_LO]))
		else $error("high nibble or margin misplaced");
	low_nib_map_a: assert property (
		reg_wr && reg_addr == `WCT_OFS_CH4_LOW_EVT
		|=> cfg.low_lim[3:0] == $past(reg_wdata[`WCT_NIB_UP])
		&& cfg.count_n == $past(reg_wdata[`WCT_NIB_LO]))
		else $error("low nibble or count misplaced");
	low_ub_map_a: assert property (
		reg_wr && reg_addr == `WCT_OFS_CH4_LOW_UB
		|=> cfg.low_lim[DW-1:4] == $past(reg_wdata))
		else $error("low upper byte not on top bits");
	write_read_a: assert property (
		reg_wr && reg_addr == `WCT_OFS_CH5_HIGH_MARG ##1 reg_rd
		&& reg_addr == `WCT_OFS_CH5_HIGH_MARG && !reg_wr
		|=> reg_rdata == $past(reg_wdata, 2))
		else $error("channel 5 margin readback wrong");
	ch3_read_a: assert property (
		reg_rd && reg_addr == `WCT_OFS_CH3_LOW_UB
		|=> reg_rdata == $past(cur_reg.ch3_low_ub))
		else $error("channel 3 low byte readback wrong");
	unmapped_zero_a: assert property (
		reg_rd && !is_mapped(reg_addr) |=> reg_rdata == `WCT_RD_IDLE)
		else $error("unmapped read not zero");
	rdata_idle_a: assert property (
		!reg_rd |=> reg_rdata == `WCT_RD_IDLE)
		else $error("read data outside read answer");
	status_read_a: assert property (
		reg_rd && reg_addr == `WCT_OFS_STATUS
		|=> reg_rdata[`WCT_ST_ALERT] == $past(ch4_alert))
		else $error("status alert bit wrong");
	// Each byte written lands in its own register
	ch3_evt_wr_a: assert property (
		reg_wr && reg_addr == `WCT_OFS_CH3_LOW_EVT
		|=> cur_reg.ch3_low_evt == $past(reg_wdata))
		else $error("channel 3 count byte not written");
	ch3_ub_wr_a: assert property (
		reg_wr && reg_addr == `WCT_OFS_CH3_LOW_UB
		|=> cur_reg.ch3_low_ub == $past(reg_wdata))
		else $error("channel 3 low byte not written");
	ch4_marg_wr_a: assert property (
		reg_wr && reg_addr == `WCT_OFS_CH4_HIGH_MARG
		|=> cur_reg.ch4_high_marg == $past(reg_wdata))
		else $error("channel 4 margin byte not written");
	ch4_hub_wr_a: assert property (
		reg_wr && reg_addr == `WCT_OFS_CH4_HIGH_UB
		|=> cur_reg.ch4_high_ub == $past(reg_wdata))
		else $error("channel 4 high byte not written");
	ch4_evt_wr_a: assert property (
		reg_wr && reg_addr == `WCT_OFS_CH4_LOW_EVT
		|=> cur_reg.ch4_low_evt == $past(reg_wdata))
		else $error("channel 4 count byte not written");
	ch4_lub_wr_a: assert property (
		reg_wr && reg_addr == `WCT_OFS_CH4_LOW_UB
		|=> cur_reg.ch4_low_ub == $past(reg_wdata))
		else $error("channel 4 low byte not written");
	ch5_marg_wr_a: assert property (
		reg_wr && reg_addr == `WCT_OFS_CH5_HIGH_MARG
		|=> cur_reg.ch5_high_marg == $past(reg_wdata))
		else $error("channel 5 margin byte not written");
	// Each read answers the byte held at the read edge
	ch3_evt_rd_a: assert property (
		reg_rd && reg_addr == `WCT_OFS_CH3_LOW_EVT
		|=> reg_rdata == $past(cur_reg.ch3_low_evt))
		else $error("channel 3 count byte readback wrong");
	ch4_marg_rd_a: assert property (
		reg_rd && reg_addr == `WCT_OFS_CH4_HIGH_MARG
		|=> reg_rdata == $past(cur_reg.ch4_high_marg))
		else $error("channel 4 margin byte readback wrong");
	ch4_hub_rd_a: assert property (
		reg_rd && reg_addr == `WCT_OFS_CH4_HIGH_UB
		|=> reg_rdata == $past(cur_reg.ch4_high_ub))
		else $error("channel 4 high byte readback wrong");
	ch4_evt_rd_a: assert property (
		reg_rd && reg_addr == `WCT_OFS_CH4_LOW_EVT
		|=> reg_rdata == $past(cur_reg.ch4_low_evt))
		else $error("channel 4 count byte readback wrong");
	ch4_lub_rd_a: assert property (
		reg_rd && reg_addr == `WCT_OFS_CH4_LOW_UB
		|=> reg_rdata == $past(cur_reg.ch4_low_ub))
		else $error("channel 4 low byte readback wrong");
	ch5_marg_rd_a: assert property (
		reg_rd && reg_addr == `WCT_OFS_CH5_HIGH_MARG
		|=> reg_rdata == $past(cur_reg.ch5_high_marg))
		else $error("channel 5 margin byte readback wrong");
	// Status and unmapped writes store nothing
	no_store_a: assert property (
		reg_wr && (reg_addr < `WCT_OFS_CH3_LOW_EVT
		|| reg_addr > `WCT_OFS_CH5_HIGH_MARG)
		|=> $stable(cur_reg.ch3_low_evt) && $stable(cur_reg.ch3_low_ub)
		&& $stable(cur_reg.ch4_high_marg) && $stable(cur_reg.ch4_high_ub)
		&& $stable(cur_reg.ch4_low_evt) && $stable(cur_reg.ch4_low_ub)
		&& $stable(cur_reg.ch5_high_marg))
		else $error("write outside the bank changed a register");
	// Read data, alert and run state all start clear
	reset_out_a: assert property (
		$past(srst) |-> reg_rdata == `WCT_RD_IDLE && !ch4_alert
		&& cfg.cnt == `WCT_CNT_ZERO && !cfg.out_now)
		else $error("outputs or run state not clear after reset");
	// Results of other channels never touch the channel 4 run
	other_chan_a: assert property (
		sample_valid && sample_chan != `WCT_CH4_ID
		|=> $stable(cfg.cnt) && $stable(cfg.out_now))
		else $error("other channel sample moved the count");
	status_bits_a: assert property (
		reg_rd && reg_addr == `WCT_OFS_STATUS
		|=> reg_rdata[`WCT_ST_CNT] == $past(cfg.cnt)
		&& reg_rdata[`WCT_ST_OUT] == $past(cfg.out_now))
		else $error("status count or out bit wrong");
	// With the last sample in window the plain limits decide
	above_high_a: assert property (
		cfg.smp_valid && !cfg.out_now && sample_data > cfg.high_lim
		|=> cfg.out_now)
		else $error("sample above high limit not out");
	below_low_a: assert property (
		cfg.smp_valid && !cfg.out_now && sample_data < cfg.low_lim
		|=> cfg.out_now)
		else $error("sample below low limit not out");
	inside_a: assert property (
		cfg.smp_valid && !cfg.out_now && sample_data <= cfg.high_lim
		&& sample_data >= cfg.low_lim |=> !cfg.out_now)
		else $error("in-window sample marked out");
	// An out sample adds one to the run until it saturates
	count_step_a: assert property (
		cfg.smp_valid && sample_data > cfg.high_lim
		&& cfg.cnt != `WCT_CNT_MAX
		|=> cfg.cnt == $past(cfg.cnt) + `WCT_CNT_ONE)
		else $error("out sample did not advance the count");
	count_hold_a: assert property (
		cfg.smp_valid && sample_data > cfg.high_lim
		&& cfg.cnt == `WCT_CNT_MAX |=> cfg.cnt == `WCT_CNT_MAX)
		else $error("saturated count moved");
	// Alert pin follows the comparator's flag with no extra stage
	alert_pin_a: assert property (
		cfg.smp_valid && sample_data > cfg.high_lim
		&& cfg.cnt == cfg.count_n |=> ch4_alert)
		else $error("alert pin missed the n+1 out sample");
	status_clear_a: assert property (
		reg_wr && reg_addr == `WCT_OFS_STATUS && reg_wdata[`WCT_ST_ALERT]
		&& !cfg.smp_valid |=> !ch4_alert)
		else $error("status write did not clear the alert");
endmodule

// ==== wct_params.svh ====
// Register offsets, reset values, field positions and fixed figures
`ifndef WCT_PARAMS_SVH
`define WCT_PARAMS_SVH
`define WCT_OFS_CH3_LOW_EVT 8'h2E
`define WCT_OFS_CH3_LOW_UB 8'h2F
`define WCT_OFS_CH4_HIGH_MARG 8'h30
`define WCT_OFS_CH4_HIGH_UB 8'h31
`define WCT_OFS_CH4_LOW_EVT 8'h32
`define WCT_OFS_CH4_LOW_UB 8'h33
`define WCT_OFS_CH5_HIGH_MARG 8'h34
`define WCT_OFS_STATUS 8'hF0
`define WCT_RST_HIGH_MARG 8'hF0
`define WCT_RST_HIGH_UB 8'hFF
`define WCT_RST_ZERO 8'h00
`define WCT_RD_IDLE 8'h00
`define WCT_NIB_UP 7:4
`define WCT_NIB_LO 3:0
`define WCT_MARGIN_SHIFT 3
`define WCT_CH4_ID 3'h4
`define WCT_ST_ALERT 0
`define WCT_ST_OUT 1
`define WCT_ST_CNT 7:4
`define WCT_CNT_ZERO 4'h0
`define WCT_CNT_ONE 4'h1
`define WCT_CNT_MAX 4'hF
`endif

// ==== wct_pkg.sv ====
// State types of the window comparator register bank
package wct_pkg;
	typedef struct packed {
		logic [7:0] ch3_low_evt;
		logic [7:0] ch3_low_ub;
		logic [7:0] ch4_high_marg;
		logic [7:0] ch4_high_ub;
		logic [7:0] ch4_low_evt;
		logic [7:0] ch4_low_ub;
		logic [7:0] ch5_high_marg;
		logic [7:0] rdata;
	} wct_regs_s;
	typedef struct packed {
		logic [3:0] cnt;
		logic prev_out;
		logic alert;
	} wct_win_s;
endpackage

// ==== wct_cfg_if.sv ====
// Limits, samples and status between register bank and comparator
`timescale 1ns/10ps
interface wct_cfg_if #(parameter int DW = 12);
	logic [DW-1:0] high_lim;
	logic [DW-1:0] low_lim;
	logic [3:0] margin;
	logic [3:0] count_n;
	logic smp_valid;
	logic [DW-1:0] smp_data;
	logic alert_clr;
	logic alert;
	logic out_now;
	logic [3:0] cnt;
	modport bank (output high_lim, low_lim, margin, count_n, smp_valid,
		smp_data, alert_clr, input alert, out_now, cnt);
	modport cmp (input high_lim, low_lim, margin, count_n, smp_valid,
		smp_data, alert_clr, output alert, out_now, cnt);
endinterface

// ==== wct_window.sv ====
// Window comparator with hysteresis and consecutive-sample counter
`timescale 1ns/10ps
`include "wct_params.svh"
module wct_window #(
	parameter int DW = 12
) (
	input wire logic clk,
	input wire logic srst,
	wct_cfg_if.cmp cfg
);
	wct_pkg::wct_win_s cur_reg;
	wct_pkg::wct_win_s cur_next;
	logic [DW-1:0] hi_eff;
	logic [DW-1:0] lo_eff;
	logic [DW-1:0] marg_w;
	logic out_hi;
	logic out_lo;
	logic out_smp;
	logic set_evt;

	function automatic logic [DW-1:0] sat_sub(input logic [DW-1:0] a,
		input logic [DW-1:0] b);
		sat_sub = (a > b) ? a - b : '0;
	endfunction

	function automatic logic [DW-1:0] sat_add(input logic [DW-1:0] a,
		input logic [DW-1:0] b);
		logic [DW:0] s;
		s = {1'b0, a} + {1'b0, b};
		sat_add = s[DW] ? '1 : s[DW-1:0];
	endfunction

	// Margin only once the channel is already out, so a noisy sample
	// near a limit does not keep restarting the count
	always_comb
	begin
		marg_w = DW'(cfg.margin) << `WCT_MARGIN_SHIFT;
		hi_eff = cur_reg.prev_out ? sat_sub(cfg.high_lim, marg_w)
			: cfg.high_lim;
		lo_eff = cur_reg.prev_out ? sat_add(cfg.low_lim, marg_w)
			: cfg.low_lim;
		out_hi = cfg.smp_data > hi_eff;
		out_lo = cfg.smp_data < lo_eff;
		out_smp = out_hi || out_lo;
		set_evt = cfg.smp_valid && out_smp
			&& (cur_reg.cnt == cfg.count_n);
	end

	always_comb
	begin
		cur_next = cur_reg;
		if (cfg.smp_valid)
		begin
			cur_next.prev_out = out_smp;
			if (!out_smp)
				cur_next.cnt = `WCT_CNT_ZERO;
			else if (cur_reg.cnt != `WCT_CNT_MAX)
				cur_next.cnt = cur_reg.cnt + `WCT_CNT_ONE;
		end
		if (set_evt)
			cur_next.alert = 1'b1;
		else if (cfg.alert_clr)
			cur_next.alert = 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			cur_reg <= '0;
		else
			cur_reg <= cur_next;
	end

	assign cfg.alert = cur_reg.alert;
	assign cfg.out_now = cur_reg.prev_out;
	assign cfg.cnt = cur_reg.cnt;

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	alert_on_count_a: assert property (
		cfg.smp_valid && out_smp && cur_reg.cnt == cfg.count_n
		|=> cur_reg.alert)
		else $error("alert not set after n+1 out samples");
	alert_not_early_a: assert property (
		!cur_reg.alert && !$past(cfg.alert_clr) ##1 cur_reg.alert
		|-> $past(cur_reg.cnt) == $past(cfg.count_n) && $past(out_smp)
		&& $past(cfg.smp_valid))
		else $error("alert set before count reached");
	in_window_restart_a: assert property (
		cfg.smp_valid && !out_smp |=> cur_reg.cnt == `WCT_CNT_ZERO
		&& !cur_reg.prev_out)
		else $error("in-window sample did not restart count");
	hyst_hold_a: assert property (
		cfg.smp_valid && cur_reg.prev_out && cfg.smp_data <= cfg.high_lim
		&& cfg.smp_data > sat_sub(cfg.high_lim,
		DW'({cfg.margin, 3'b000})) |=> cur_reg.prev_out)
		else $error("margin not applied below high limit");
	clear_drop_a: assert property (
		cfg.alert_clr && !set_evt |=> !cur_reg.alert)
		else $error("alert clear lost");
	set_beats_clear_a: assert property (
		cfg.alert_clr && set_evt |=> cur_reg.alert)
		else $error("clear beat simultaneous set");
endmodule

// ==== wct_host.sv ====
// Host model driving the register port of the threshold bank
`timescale 1ns/10ps
module wct_host (
	input wire logic clk,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	initial
	begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// Idle lines flip so stale values never look like a request
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask

	// Write then read with no idle cycle between the strobes
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] dw,
		output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= dw;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~dw;
		#1;
		d = reg_rdata;
	endtask
endmodule

// ==== window_comparator_threshold_regs_tb_top.sv ====
// Self-checking bench for the window comparator register bank
`timescale 1ns/10ps
`include "wct_params.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
	miscompares++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module window_comparator_threshold_regs_tb_top;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, wv;
	logic reg_wr, reg_rd, ch4_alert;
	logic sample_valid = 1'b0;
	logic [2:0] sample_chan = 3'h0;
	logic [11:0] sample_data = 12'h000;
	logic [31:0] seed = 32'h0000_0062;
	logic [31:0] r;
	int miscompares = 0;
	int tests_run = 0;
	int hi, lo, m, n, cnt, pout, al, eh, el, o;
	logic [7:0] rst_tab [7] = '{8'h00, 8'h00, 8'hF0, 8'hFF, 8'h00, 8'h00,
		8'hF0};

	wct_regs #(.DW(12)) dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sample_valid(sample_valid),
		.sample_chan(sample_chan), .sample_data(sample_data),
		.ch4_alert(ch4_alert));
	wct_host host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	initial
	begin
		forever #12.5 clk = ~clk;
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic report_and_stop();
		$display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
		if (miscompares == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Reference comparator kept in integers, updated per channel 4 sample
	task automatic smp(input logic [2:0] ch, input logic [11:0] d);
		@(posedge clk);
		sample_valid <= 1'b1;
		sample_chan <= ch;
		sample_data <= d;
		@(posedge clk);
		sample_valid <= 1'b0;
		if (ch == 3'h4)
		begin
			eh = pout ? hi - m * 8 : hi;
			el = pout ? lo + m * 8 : lo;
			o = (d > eh) || (d < el);
			cnt = o ? ((cnt < 15) ? cnt + 1 : 15) : 0;
			if (o && cnt == n + 1) al = 1;
			pout = o;
		end
		#1;
		`CHK("ch4_alert", al[0], ch4_alert)
	endtask

	initial
	begin
		repeat (100000) @(posedge clk);
		miscompares++;
		$display("[ERR] run limit exp finish got hang");
		report_and_stop();
	end

	initial
	begin
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 7; i++)
		begin
			host.rd(8'h2E + 8'(i), rv);
			`CHK("reset value", rst_tab[i], rv)
		end
		host.rd(8'h40, rv);
		`CHK("unmapped read", 8'h00, rv)
		$display("test reset values done");
		for (int i = 0; i < 7; i++)
		begin
			r = xs();
			wv = r[7:0];
			host.wr(8'h2E + 8'(i), wv);
			host.rd(8'h2E + 8'(i), rv);
			`CHK("readback", wv, rv)
		end
		r = xs();
		wv = r[7:0];
		host.wr_rd(`WCT_OFS_CH5_HIGH_MARG, wv, rv);
		`CHK("write then read", wv, rv)
		$display("test readback done");
		// Limits drawn so high stays above low plus margin
		for (int t = 0; t < 6; t++)
		begin
			r = xs();
			hi = 32'h0000_0A00 + r[7:0];
			lo = 32'h0000_0300 + r[15:8];
			m = r[19:16];
			n = r[21:20];
			host.wr(8'h30, {hi[3:0], m[3:0]});
			host.wr(8'h31, hi[11:4]);
			host.wr(8'h32, {lo[3:0], n[3:0]});
			host.wr(8'h33, lo[11:4]);
			for (int k = 0; k < 40; k++)
			begin
				r = xs();
				smp(r[0] ? 3'h4 : r[3:1], r[15:4]);
				if (al != 0)
				begin
					host.rd(`WCT_OFS_STATUS, rv);
					`CHK("status alert", 1'b1, rv[0])
					`CHK("status out", pout[0], rv[1])
					`CHK("status count", cnt[3:0], rv[7:4])
					host.wr(`WCT_OFS_STATUS, 8'h01);
					al = 0;
					smp(3'h4, 12'h700);
				end
			end
		end
		$display("test window alert done");
		// Clear and the n+1-th out sample in one cycle: set wins
		host.wr(8'h32, {lo[3:0], 4'h0});
		n = 0;
		smp(3'h4, 12'h700);
		fork
			host.wr(`WCT_OFS_STATUS, 8'h01);
			smp(3'h4, 12'hFFF);
		join
		host.rd(`WCT_OFS_STATUS, rv);
		`CHK("alert after set and clear", 1'b1, rv[0])
		host.wr(`WCT_OFS_STATUS, 8'h01);
		al = 0;
		smp(3'h4, 12'h700);
		$display("test set beats clear done");
		report_and_stop();
	end
endmodule
